// >>> verilog/jtp_port.sv
/*
  Device end of the serial test port: pin sampling, TAP controller,
  instruction register, bypass and one data register, test data output
  timing, pull resistor controls and a FIFO for words shifted in.
  Assumes test pins arrive asynchronously and are oversampled by clk;
  the test clock must be slower than clk/4 (bench: 160 ns vs 20 ns).
*/
// Behaviour
// - Mode select sampled on rising test clock
// - Data input captured on rising test clock
// - Data output driven only in shift states
// - Data output changes on falling test clock
// - Test clock times all test logic except test reset, which acts on clk
// - Pull-down enabled on test clock pin
// - Mode/data pull-ups on unless disable bit set
// - Low test reset resets TAP on clk, after the two-flop synchroniser
`include "jtp_params.svh"
`default_nettype none
module jtp_port #(
  parameter int IR_LEN = `JTP_IR_LEN,
  parameter int DR_LEN = `JTP_DR_LEN,
  parameter int FIFO_DEPTH = `JTP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic test_clk,
  input wire logic test_mode,
  input wire logic test_din,
  input wire logic test_rst_n,
  output logic test_dout_o,
  output logic test_dout_oe,
  output logic test_clk_pd_en,
  output logic test_mode_pu_en,
  output logic test_din_pu_en,
  output logic test_rst_pu_en,
  input wire logic pull_resistor_disable_register,
  output logic [DR_LEN-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [DR_LEN-1:0] tx_data,
  output logic [IR_LEN-1:0] ir_value,
  output logic [3:0] tap_state
);
  logic tck_s, tms_s, tdi_s, trst_s_n;
  logic tck_prev_q, tck_prev_d;
  logic rise, fall;
  jtp_pkg::jtp_state_t st_q, st_d;
  logic [IR_LEN-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [DR_LEN-1:0] dr_sh_q, dr_sh_d;
  logic byp_q, byp_d;
  logic tdo_q, tdo_d, oe_q, oe_d;
  logic [DR_LEN-1:0] pend_q, pend_d;
  logic pend_v_q, pend_v_d;
  logic fifo_ready;
  logic bypass_sel;
  logic pull_dis_q, pull_dis_d;

  jtp_sync #(.RST_VAL(1'b0)) u_sync_tck (
    .clk(clk), .rst(rst), .d(test_clk), .q(tck_s)
  );
  jtp_sync #(.RST_VAL(1'b1)) u_sync_tms (
    .clk(clk), .rst(rst), .d(test_mode), .q(tms_s)
  );
  jtp_sync #(.RST_VAL(1'b1)) u_sync_tdi (
    .clk(clk), .rst(rst), .d(test_din), .q(tdi_s)
  );
  jtp_sync #(.RST_VAL(1'b0)) u_sync_trst (
    .clk(clk), .rst(rst), .d(test_rst_n), .q(trst_s_n)
  );

  // Edges of the sampled test clock pace every test register
  assign rise = tck_s && !tck_prev_q;
  assign fall = !tck_s && tck_prev_q;
  assign bypass_sel = (ir_q == IR_LEN'(`JTP_IR_BYPASS));

  // Pull enables are pad controls; disabling pulls is a software choice
  always_comb begin
    pull_dis_d = pull_resistor_disable_register;
    test_clk_pd_en = 1'b1;
    test_mode_pu_en = !pull_dis_q;
    test_din_pu_en = !pull_dis_q;
    test_rst_pu_en = !pull_dis_q;
  end

  always_comb begin
    st_d = st_q;
    if (rise) begin
      case (st_q)
        jtp_pkg::JTP_RESET: st_d = tms_s ? jtp_pkg::JTP_RESET : jtp_pkg::JTP_IDLE;
        jtp_pkg::JTP_IDLE: st_d = tms_s ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_IDLE;
        jtp_pkg::JTP_SEL_DR: st_d = tms_s ? jtp_pkg::JTP_SEL_IR : jtp_pkg::JTP_CAP_DR;
        jtp_pkg::JTP_CAP_DR: st_d = tms_s ? jtp_pkg::JTP_EXIT1_DR : jtp_pkg::JTP_SHIFT_DR;
        jtp_pkg::JTP_SHIFT_DR: st_d = tms_s ? jtp_pkg::JTP_EXIT1_DR : jtp_pkg::JTP_SHIFT_DR;
        jtp_pkg::JTP_EXIT1_DR: st_d = tms_s ? jtp_pkg::JTP_UPD_DR : jtp_pkg::JTP_PAUSE_DR;
        jtp_pkg::JTP_PAUSE_DR: st_d = tms_s ? jtp_pkg::JTP_EXIT2_DR : jtp_pkg::JTP_PAUSE_DR;
        jtp_pkg::JTP_EXIT2_DR: st_d = tms_s ? jtp_pkg::JTP_UPD_DR : jtp_pkg::JTP_SHIFT_DR;
        jtp_pkg::JTP_UPD_DR: st_d = tms_s ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_IDLE;
        jtp_pkg::JTP_SEL_IR: st_d = tms_s ? jtp_pkg::JTP_RESET : jtp_pkg::JTP_CAP_IR;
        jtp_pkg::JTP_CAP_IR: st_d = tms_s ? jtp_pkg::JTP_EXIT1_IR : jtp_pkg::JTP_SHIFT_IR;
        jtp_pkg::JTP_SHIFT_IR: st_d = tms_s ? jtp_pkg::JTP_EXIT1_IR : jtp_pkg::JTP_SHIFT_IR;
        jtp_pkg::JTP_EXIT1_IR: st_d = tms_s ? jtp_pkg::JTP_UPD_IR : jtp_pkg::JTP_PAUSE_IR;
        jtp_pkg::JTP_PAUSE_IR: st_d = tms_s ? jtp_pkg::JTP_EXIT2_IR : jtp_pkg::JTP_PAUSE_IR;
        jtp_pkg::JTP_EXIT2_IR: st_d = tms_s ? jtp_pkg::JTP_UPD_IR : jtp_pkg::JTP_SHIFT_IR;
        jtp_pkg::JTP_UPD_IR: st_d = tms_s ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_IDLE;
        default: st_d = jtp_pkg::JTP_RESET;
      endcase
    end
  end

  // Shift paths; capture loads the IR pattern, tx_data and a bypass 0, shift takes the data input
  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    dr_sh_d = dr_sh_q;
    byp_d = byp_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q && !fifo_ready;
    if (rise) begin
      case (st_q)
        jtp_pkg::JTP_CAP_IR: ir_sh_d = IR_LEN'(`JTP_IR_CAPTURE);
        jtp_pkg::JTP_SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[IR_LEN-1:1]};
        jtp_pkg::JTP_UPD_IR: ir_d = ir_sh_q;
        jtp_pkg::JTP_CAP_DR: begin
          dr_sh_d = tx_data;
          byp_d = 1'b0;
        end
        jtp_pkg::JTP_SHIFT_DR: begin
          if (bypass_sel) begin
            byp_d = tdi_s;
          end else begin
            dr_sh_d = {tdi_s, dr_sh_q[DR_LEN-1:1]};
          end
        end
        jtp_pkg::JTP_UPD_DR: begin
          if (!bypass_sel) begin
            pend_d = dr_sh_q;
            pend_v_d = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Output bit and its enable move on falling test clock edges; test reset clears them on clk
  always_comb begin
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (fall) begin
      oe_d = (st_q == jtp_pkg::JTP_SHIFT_IR) || (st_q == jtp_pkg::JTP_SHIFT_DR);
      if (st_q == jtp_pkg::JTP_SHIFT_IR) begin
        tdo_d = ir_sh_q[0];
      end else if (st_q == jtp_pkg::JTP_SHIFT_DR) begin
        tdo_d = bypass_sel ? byp_q : dr_sh_q[0];
      end
    end
    tck_prev_d = tck_s;
  end

  // Test reset: asynchronous by intent, seen here after the synchroniser
  // so that no unsynchronised level reaches the state register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= jtp_pkg::JTP_RESET;
      ir_sh_q <= IR_LEN'(`JTP_IR_RESET);
      ir_q <= IR_LEN'(`JTP_IR_RESET);
      oe_q <= 1'b0;
      tdo_q <= 1'b0;
    end else if (!trst_s_n) begin
      st_q <= jtp_pkg::JTP_RESET;
      ir_sh_q <= IR_LEN'(`JTP_IR_RESET);
      ir_q <= IR_LEN'(`JTP_IR_RESET);
      oe_q <= 1'b0;
      tdo_q <= 1'b0;
    end else begin
      st_q <= (st_q == jtp_pkg::JTP_RESET && !rise) ? st_q : st_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= (st_q == jtp_pkg::JTP_RESET) ? IR_LEN'(`JTP_IR_RESET) : ir_d;
      oe_q <= oe_d;
      tdo_q <= tdo_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_prev_q <= 1'b0;
      dr_sh_q <= '0;
      byp_q <= 1'b0;
      pend_q <= '0;
      pend_v_q <= 1'b0;
      pull_dis_q <= `JTP_PULL_DIS_RESET;
    end else begin
      tck_prev_q <= tck_prev_d;
      dr_sh_q <= dr_sh_d;
      byp_q <= byp_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      pull_dis_q <= pull_dis_d;
    end
  end

  // A word that finds the FIFO full waits in pend; a newer update overwrites it
  jtp_fifo #(.WIDTH(DR_LEN), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(pend_v_q),
    .in_ready(fifo_ready),
    .in_data(pend_q),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign test_dout_o = tdo_q;
  assign test_dout_oe = oe_q;
  assign ir_value = ir_q;
  assign tap_state = st_q;
endmodule : jtp_port
`default_nettype wire

// >>> common/jtp_params.svh
/*
  Constants of the test-port pin block: instruction codes, FIFO depth, shift
  register lengths, pull control defaults.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef JTP_PARAMS_SVH
`define JTP_PARAMS_SVH
`define JTP_IR_LEN 4
`define JTP_IR_RESET 4'h1
`define JTP_IR_BYPASS 4'hf
`define JTP_IR_CAPTURE 4'h1
`define JTP_DR_LEN 8
`define JTP_PULL_DIS_RESET 1'b0
`define JTP_FIFO_DEPTH 8
`define JTP_SYNC_STAGES 2
`endif

// >>> common/jtp_pkg.sv
/*
  Types of the test-port pin block: the TAP controller state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package jtp_pkg;
  typedef enum logic [3:0] {
    JTP_RESET      = 4'h0,
    JTP_IDLE       = 4'h1,
    JTP_SEL_DR     = 4'h3,
    JTP_CAP_DR     = 4'h2,
    JTP_SHIFT_DR   = 4'h6,
    JTP_EXIT1_DR   = 4'h7,
    JTP_PAUSE_DR   = 4'h5,
    JTP_EXIT2_DR   = 4'h4,
    JTP_UPD_DR     = 4'hc,
    JTP_SEL_IR     = 4'hd,
    JTP_CAP_IR     = 4'hf,
    JTP_SHIFT_IR   = 4'he,
    JTP_EXIT1_IR   = 4'ha,
    JTP_PAUSE_IR   = 4'hb,
    JTP_EXIT2_IR   = 4'h9,
    JTP_UPD_IR     = 4'h8
  } jtp_state_t;
endpackage : jtp_pkg
`default_nettype wire

// >>> verilog/jtp_sync.sv
/*
  Two-flop synchroniser for one bit with a reset value.
  Assumes d comes from outside the clk domain.
*/
`default_nettype none
module jtp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic sync_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule : jtp_sync
`default_nettype wire

// >>> verilog/jtp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides; read data registered.
  Assumes a single clock; width and depth as parameters, depth a power of 2.
*/
`default_nettype none
module jtp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] dat_q, dat_d;
  logic ov_q, ov_d;
  logic push, pop, load;
  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    push = in_valid && in_ready;
    load = (cnt_q != '0) && (!ov_q || out_ready);
    pop = load;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    dat_d = load ? mem_q[rd_q] : dat_q;
    ov_d = load ? 1'b1 : (out_ready ? 1'b0 : ov_q);
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      dat_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      ov_q <= ov_d;
    end
  end
  assign out_valid = ov_q;
  assign out_data = dat_q;
endmodule : jtp_fifo
`default_nettype wire

// >>> verif/jtp_port_assertions.sv
/* Concurrent checks on the test-port pins of jtp_port.
   Assumes one clock domain, clk, with rst as its reset. */
`default_nettype none
module jtp_port_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic test_clk,
  input wire logic test_rst_n,
  input wire logic test_dout_o,
  input wire logic test_dout_oe,
  input wire logic test_clk_pd_en,
  input wire logic test_mode_pu_en,
  input wire logic test_din_pu_en,
  input wire logic test_rst_pu_en,
  input wire logic pull_resistor_disable_register,
  input wire logic [3:0] tap_state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_clk_pull_down: assert property (test_clk_pd_en)
    else $error("test clock pull-down is off");
  a_pull_up_ctl: assert property (test_mode_pu_en == !$past(pull_resistor_disable_register)
    && test_din_pu_en == test_mode_pu_en && test_rst_pu_en == test_mode_pu_en)
    else $error("pull-up enables do not follow the disable bit");
  a_oe_rise_shift: assert property ($rose(test_dout_oe) |-> tap_state inside
    {jtp_pkg::JTP_SHIFT_DR, jtp_pkg::JTP_SHIFT_IR}) else $error("output enabled outside shift");
  a_oe_fall_exit: assert property ($fell(test_dout_oe) |-> !(tap_state inside
    {jtp_pkg::JTP_SHIFT_DR, jtp_pkg::JTP_SHIFT_IR})) else $error("output released in shift");
  a_dout_on_fall: assert property (($changed(test_dout_o) || $changed(test_dout_oe))
    && test_rst_n |-> !$past(test_clk)) else $error("data output moved in high phase");
  a_state_on_rise: assert property ($changed(tap_state) && test_rst_n |-> $past(test_clk))
    else $error("state moved in low phase");
  a_reset_to_idle: assert property ($past(tap_state) == jtp_pkg::JTP_RESET
    && $changed(tap_state) |-> tap_state == jtp_pkg::JTP_IDLE) else $error("bad exit from reset");
  a_trst_holds: assert property (!test_rst_n [*5] |-> tap_state == jtp_pkg::JTP_RESET
    && !test_dout_oe) else $error("test reset not honoured");
endmodule : jtp_port_assertions
bind jtp_port jtp_port_assertions jtp_port_assertions_i (.clk(clk), .rst(rst),
  .test_clk(test_clk), .test_rst_n(test_rst_n), .test_dout_o(test_dout_o),
  .test_dout_oe(test_dout_oe), .test_clk_pd_en(test_clk_pd_en),
  .test_mode_pu_en(test_mode_pu_en), .test_din_pu_en(test_din_pu_en),
  .test_rst_pu_en(test_rst_pu_en), .tap_state(tap_state),
  .pull_resistor_disable_register(pull_resistor_disable_register));
`default_nettype wire

// >>> verif/jtp_host.sv
/* Test-port host model: makes the 160 ns test clock and walks the TAP.
   Assumes the bench calls its tasks at a falling edge of clk. */
`default_nettype none
module jtp_host (
  input wire logic clk,
  input wire logic tdo_line,
  output logic test_clk,
  output logic test_mode,
  output logic test_din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    test_clk = 1'b0;
    test_mode = 1'b1;
    test_din = 1'b1;
  end
  // Mode and data move with the fall, well before the next rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    test_mode = tms;
    test_din = tdi;
    repeat (4) @(negedge clk);
    test_clk = 1'b1;
    tdo = tdo_line;
    repeat (4) @(negedge clk);
    test_clk = 1'b0;
  endtask : tick
  task automatic scan(input logic ir, input int n, input logic [7:0] din,
                      output logic [7:0] dout);
    logic b;
    dout = 8'h00;
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, din[k], b);
      dout[k] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : scan
endmodule : jtp_host
`default_nettype wire

// >>> verif/jtp_port_tb_top.sv
/* Self-checking bench for jtp_port with the host model on its test pins.
   Assumes default parameters: 4-bit instruction, 8-bit data, 8-word FIFO. */
`include "jtp_params.svh"
`default_nettype none
module jtp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, tck, tms, tdi, trst_n, dout, oe, pd, pum, pud, pur, dis, rx_valid, rx_ready;
  logic [7:0] rx_data, tx_data, got;
  logic [3:0] ir_value, tap_state;
  wire logic tdo_line;
  int fails = 0;
  int samples_checked = 0;
  // Released output reads as the pull-up level
  assign tdo_line = oe ? dout : 1'b1;
  jtp_port jtp_port_i (.clk(clk), .rst(rst), .test_clk(tck), .test_mode(tms), .test_din(tdi),
    .test_rst_n(trst_n), .test_dout_o(dout), .test_dout_oe(oe), .test_clk_pd_en(pd),
    .test_mode_pu_en(pum), .test_din_pu_en(pud), .test_rst_pu_en(pur),
    .pull_resistor_disable_register(dis), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .ir_value(ir_value), .tap_state(tap_state));
  jtp_host jtp_host_i (.clk(clk), .tdo_line(tdo_line), .test_clk(tck), .test_mode(tms),
    .test_din(tdi));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic t_defaults;
    check("state", {4'h0, jtp_pkg::JTP_RESET}, {4'h0, tap_state});
    check("oe", 8'h00, {7'h00, oe});
    check("ir", {4'h0, `JTP_IR_RESET}, {4'h0, ir_value});
    check("pulls", 8'h0f, {4'h0, pd, pum, pud, pur});
  endtask : t_defaults
  task automatic t_pulls;
    dis = 1'b1;
    repeat (3) @(negedge clk);
    check("pulls off", 8'h08, {4'h0, pd, pum, pud, pur});
    dis = 1'b0;
    repeat (3) @(negedge clk);
    check("pulls on", 8'h0f, {4'h0, pd, pum, pud, pur});
  endtask : t_pulls
  task automatic t_ir;
    logic b;
    jtp_host_i.tick(1'b0, 1'b1, b);
    jtp_host_i.scan(1'b1, 4, 8'h02, got);
    check("ir out", {4'h0, `JTP_IR_CAPTURE}, {4'h0, got[3:0]});
    check("ir", 8'h02, {4'h0, ir_value});
    check("oe idle", 8'h00, {7'h00, oe});
  endtask : t_ir
  task automatic t_fifo;
    int w;
    rx_ready = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tx_data = 8'h5a ^ 8'(i);
      jtp_host_i.scan(1'b0, 8, 8'h30 + 8'(i), got);
      check("dr out", 8'h5a ^ 8'(i), got);
    end
    for (int i = 0; i < 8; i++) begin
      w = 0;
      while (rx_valid !== 1'b1 && w < 20) begin
        @(negedge clk);
        w++;
      end
      check("rx word", 8'h30 + 8'(i), rx_data);
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
      @(negedge clk);
    end
    repeat (4) @(negedge clk);
    check("drained", 8'h00, {7'h00, rx_valid});
  endtask : t_fifo
  // Bypass: one-stage path, captured 0 leads, no word reaches the stream
  task automatic t_bypass;
    jtp_host_i.scan(1'b1, 4, 8'h0f, got);
    check("byp ir", 8'h0f, {4'h0, ir_value});
    tx_data = 8'hff;
    jtp_host_i.scan(1'b0, 8, 8'ha5, got);
    check("byp out", 8'h4a, got);
    repeat (6) @(negedge clk);
    check("byp rx", 8'h00, {7'h00, rx_valid});
  endtask : t_bypass
  task automatic t_trst;
    logic b;
    jtp_host_i.tick(1'b1, 1'b1, b);
    jtp_host_i.tick(1'b0, 1'b1, b);
    jtp_host_i.tick(1'b0, 1'b1, b);
    jtp_host_i.tick(1'b0, 1'b1, b);
    check("oe shift", 8'h01, {7'h00, oe});
    trst_n = 1'b0;
    repeat (6) @(negedge clk);
    check("trst state", {4'h0, jtp_pkg::JTP_RESET}, {4'h0, tap_state});
    check("trst oe", 8'h00, {7'h00, oe});
    trst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : t_trst
  initial begin
    rst = 1'b1;
    trst_n = 1'b0;
    dis = 1'b0;
    rx_ready = 1'b0;
    tx_data = 8'h00;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    trst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_defaults();
    t_pulls();
    t_ir();
    t_fifo();
    t_bypass();
    t_trst();
    conclude();
  end
  initial begin
    #200us;
    fails++;
    conclude();
  end
endmodule : jtp_port_tb_top
`default_nettype wire
